// >>> verilog/dpc_port_top.sv
// one counter-addressed port of a synchronous dual-port memory
//
// How it works
// (RQ1) With no load and no advance the stored address stays, so read data holds.
// (RQ2) Load strobe low selects the pin address, high selects the counter value.
// (RQ3) A held load strobe takes a new pin address on every rising edge.
// (RQ4) A counter clear costs no idle cycle; the port still accesses that cycle.
// (RQ5) A read or write in the clear cycle goes to location zero.
// (RQ6) Advance enable low steps the address by one and a write lands there.
// (RQ7) Address, data and control pins are all captured on the rising edge.
// (RQ8) The array write comes from the registered request, not from the edge.
// (RQ9) The output enable pin gates the data drivers at once, with no clock.
// (RQ10) One cycle with the port deselected powers the port down.
// (RQ11) Pipelined outputs need two selected cycles before driving again.
// (RQ12) Each cycle's output drive follows the controls of the previous cycle, or of two cycles back when pipelined.
// (RQ13) The controller passes the bench's two selects straight through to the port pins.
// (RQ14) Deselect or a dropped lane select floats that lane after the next edge, or after the second edge when pipelined.
// (RQ15) After a read-to-write turn with no idle cycle the controller does not rewrite; the bench inserts a deselected cycle before such a write instead.
// (RQ16) Address is 14 bits, data 18 bits in two 9-bit lanes with own selects.
`timescale 1ns/1ns
`default_nettype none
`include "dpc_consts.svh"
module dpc_port_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus write side
  input wire logic [`DPC_AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // register bus read side
  input wire logic [`DPC_AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // memory port controls and address
  input wire dpc_pkg::dpc_port_ctrl_t port_ctrl,
  input wire logic [`DPC_ADDR_W-1:0] port_addr,
  // data pins, split into in, out and per-lane enable
  input wire logic [`DPC_DATA_W-1:0] data_in,
  output logic [`DPC_DATA_W-1:0] data_out,
  output logic [`DPC_LANES-1:0] data_oe,
  // asynchronous output enable
  input wire logic output_enable_n
);

  dpc_pkg::dpc_port_ctrl_t ctl_q;
  dpc_pkg::dpc_status_t status;
  logic [`DPC_ADDR_W-1:0] addr_q;
  logic [`DPC_DATA_W-1:0] wdata_q;
  logic [`DPC_ADDR_W-1:0] cnt_q;
  logic [`DPC_ADDR_W-1:0] eff_addr;
  logic selected;
  logic wr_pulse;
  logic [`DPC_LANES-1:0] lane_on;
  logic [`DPC_LANES-1:0] wr_lane;
  logic [`DPC_LANES-1:0] rd_en;
  logic [`DPC_LANES-1:0] en1_q;
  logic [`DPC_LANES-1:0] out_en_q;
  logic [`DPC_DATA_W-1:0] rd1_q;
  logic [1:0] run_q;
  logic pd_q;
  logic output_latency_select;

  // register bus slave
  dpc_axil_regs u_regs (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .output_latency_select(output_latency_select),
    .status(status)
  );

  // input registers on the rising edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_q <= `DPC_CTRL_RST;
      addr_q <= '0;
      wdata_q <= '0;
    end else begin
      ctl_q <= port_ctrl; // RQ7
      addr_q <= port_addr; // RQ7 RQ3
      wdata_q <= data_in; // RQ7
    end
  end

  // access address: clear, then load, then advance, else hold
  always_comb begin
    if (!ctl_q.count_clear_n) begin
      eff_addr = '0; // RQ5 RQ4
    end else if (!ctl_q.address_load_strobe_n) begin
      eff_addr = addr_q; // RQ2
    end else if (!ctl_q.count_advance_enable_n) begin
      eff_addr = cnt_q + `DPC_ADDR_W'(1); // RQ6
    end else begin
      eff_addr = cnt_q; // RQ1 RQ2
    end
  end

  // counter keeps the last access address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= eff_addr; // RQ1 RQ6
    end
  end

  // decode of the registered controls
  assign selected = ~ctl_q.select_active_low & ctl_q.select_active_high;
  assign lane_on = {~ctl_q.upper_lane_select_n, ~ctl_q.lower_lane_select_n};
  assign wr_pulse = selected & ~ctl_q.read_write_n;
  assign wr_lane = lane_on & {`DPC_LANES{wr_pulse}}; // RQ8 RQ16
  assign rd_en = lane_on & {`DPC_LANES{selected & ctl_q.read_write_n}};

  // power-down and wake tracking
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pd_q <= 1'b1;
      run_q <= 2'h0;
    end else if (!selected) begin
      pd_q <= 1'b1; // RQ10
      run_q <= 2'h0;
    end else begin
      pd_q <= 1'b0;
      if (run_q != `DPC_WAKE_CYCLES) begin
        run_q <= run_q + 2'h1; // RQ11
      end
    end
  end

  // lane drive follows the previous cycle's controls, or the cycle before that when pipelined
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en1_q <= '0;
      out_en_q <= '0;
    end else begin
      en1_q <= rd_en;
      if (!output_latency_select) begin
        out_en_q <= rd_en; // RQ12 RQ14
      end else if (run_q == `DPC_WAKE_CYCLES) begin
        out_en_q <= en1_q; // RQ11 RQ12
      end else begin
        out_en_q <= '0; // RQ11
      end
    end
  end

  // storage, read stage and output register per lane
  for (genvar g = 0; g < `DPC_LANES; g++) begin : g_lane
    logic [`DPC_LANE_W-1:0] mem_q [0:(1 << `DPC_ADDR_W)-1];

    // write from the registered request
    always_ff @(posedge aclk) begin
      if (wr_lane[g]) begin
        mem_q[eff_addr] <= wdata_q[g*`DPC_LANE_W +: `DPC_LANE_W]; // RQ8 RQ6 RQ5
      end
    end

    // flow-through takes the array, pipelined the extra stage
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        rd1_q[g*`DPC_LANE_W +: `DPC_LANE_W] <= '0;
        data_out[g*`DPC_LANE_W +: `DPC_LANE_W] <= '0;
      end else begin
        rd1_q[g*`DPC_LANE_W +: `DPC_LANE_W] <= mem_q[eff_addr];
        if (output_latency_select) begin
          data_out[g*`DPC_LANE_W +: `DPC_LANE_W] <= rd1_q[g*`DPC_LANE_W +: `DPC_LANE_W];
        end else begin
          data_out[g*`DPC_LANE_W +: `DPC_LANE_W] <= mem_q[eff_addr]; // RQ16
        end
      end
    end
  end

  // output enable acts on the drivers without a clock
  assign data_oe = out_en_q & {`DPC_LANES{~output_enable_n}}; // RQ9 RQ14

  // state seen by software
  assign status.count = cnt_q;
  assign status.awake = (run_q == `DPC_WAKE_CYCLES);
  assign status.powered_down = pd_q;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_hold_addr; // RQ1
    ctl_q.address_load_strobe_n && ctl_q.count_advance_enable_n && ctl_q.count_clear_n
      |=> cnt_q == $past(cnt_q);
  endproperty
  a_hold_addr: assert property (p_hold_addr) else $error("address moved with no load or advance"); // RQ1

  property p_load_pin; // RQ2
    !ctl_q.address_load_strobe_n && ctl_q.count_clear_n |-> eff_addr == addr_q;
  endproperty
  a_load_pin: assert property (p_load_pin) else $error("load strobe did not use pin address"); // RQ2

  property p_load_every_edge; // RQ3
    port_ctrl.count_clear_n && !port_ctrl.address_load_strobe_n
      |=> eff_addr == $past(port_addr);
  endproperty
  a_load_every_edge: assert property (p_load_every_edge) else $error("pin address not taken"); // RQ3

  property p_clear_zero; // RQ5
    !ctl_q.count_clear_n |-> eff_addr == '0 ##1 cnt_q == '0;
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("clear did not go to zero"); // RQ5

  property p_clear_no_idle; // RQ4
    !ctl_q.count_clear_n && !output_latency_select && rd_en[0]
      |=> out_en_q[0] && data_out[8:0] === $past(g_lane[0].mem_q[0]);
  endproperty
  a_clear_no_idle: assert property (p_clear_no_idle) else $error("clear cycle lost its read"); // RQ4

  property p_advance; // RQ6
    ctl_q.address_load_strobe_n && !ctl_q.count_advance_enable_n && ctl_q.count_clear_n
      |=> cnt_q == $past(cnt_q) + `DPC_ADDR_W'(1);
  endproperty
  a_advance: assert property (p_advance) else $error("advance did not step by one"); // RQ6

  property p_self_write; // RQ8
    wr_lane[0] |=> g_lane[0].mem_q[$past(eff_addr)] == $past(wdata_q[8:0]);
  endproperty
  a_self_write: assert property (p_self_write) else $error("registered write not stored"); // RQ8

  property p_oe_async; // RQ9
    output_enable_n |-> data_oe == '0;
  endproperty
  a_oe_async: assert property (p_oe_async) else $error("drivers on with output enable high"); // RQ9

  property p_power_down; // RQ10
    !selected |=> pd_q && !status.awake;
  endproperty
  a_power_down: assert property (p_power_down) else $error("deselect did not power down"); // RQ10

  property p_pipe_wake; // RQ11
    output_latency_select && !selected ##1 selected |=> ##1 out_en_q == '0;
  endproperty
  a_pipe_wake: assert property (p_pipe_wake) else $error("pipelined drive too early"); // RQ11

  property p_prev_ctrl; // RQ12
    !output_latency_select && $stable(output_latency_select) |=> out_en_q == $past(rd_en);
  endproperty
  a_prev_ctrl: assert property (p_prev_ctrl) else $error("drive not from previous controls"); // RQ12

  property p_lane_float; // RQ14
    !output_latency_select && (!selected || ctl_q.upper_lane_select_n) |=> !out_en_q[1];
  endproperty
  a_lane_float: assert property (p_lane_float) else $error("upper lane still driven"); // RQ14

  property p_read_data; // RQ16
    !output_latency_select && rd_en[1]
      |=> data_out[17:9] === $past(g_lane[1].mem_q[eff_addr]);
  endproperty
  a_read_data: assert property (p_read_data) else $error("upper lane read data wrong"); // RQ16

  property p_read_lower; // RQ16
    !output_latency_select && rd_en[0]
      |=> data_out[8:0] === $past(g_lane[0].mem_q[eff_addr]);
  endproperty
  a_read_lower: assert property (p_read_lower) else $error("lower lane data wrong"); // RQ16

  property p_lower_float; // RQ14
    !output_latency_select && (!selected || ctl_q.lower_lane_select_n) |=> !out_en_q[0];
  endproperty
  a_lower_float: assert property (p_lower_float) else $error("lower lane still driven"); // RQ14

  property p_pipe_data; // RQ12
    output_latency_select |=> data_out === $past(rd1_q);
  endproperty
  a_pipe_data: assert property (p_pipe_data) else $error("pipelined data not staged"); // RQ12

  property p_pipe_drive; // RQ12
    output_latency_select && status.awake |=> out_en_q == $past(en1_q);
  endproperty
  a_pipe_drive: assert property (p_pipe_drive) else $error("pipelined drive wrong"); // RQ12

  property p_awake; // RQ11
    selected ##1 selected |=> status.awake;
  endproperty
  a_awake: assert property (p_awake) else $error("two selected cycles not awake"); // RQ11

  property p_write_upper; // RQ8
    wr_lane[1] |=> g_lane[1].mem_q[$past(eff_addr)] == $past(wdata_q[17:9]);
  endproperty
  a_write_upper: assert property (p_write_upper) else $error("upper write not stored"); // RQ8

endmodule // dpc_port_top
`default_nettype wire

// >>> verilog/dpc_consts.svh
// constants for the counter-addressed memory port
`ifndef DPC_CONSTS_SVH
`define DPC_CONSTS_SVH

// port geometry
`define DPC_ADDR_W 14
`define DPC_DATA_W 18
`define DPC_LANE_W 9
`define DPC_LANES 2

// selected cycles needed before pipelined outputs drive again
`define DPC_WAKE_CYCLES 2'h2

// control pins after reset: deselected, no load, no count, no clear, read
`define DPC_CTRL_RST 8'hBF

// register bus map
`define DPC_AXI_AW 8
`define DPC_OFF_CTRL 8'h00
`define DPC_OFF_STATUS 8'h04
`define DPC_CTRL_PIPE_BIT 0
`define DPC_CTRL_PIPE_RST 1'b0
`define DPC_STAT_PD_BIT 0
`define DPC_STAT_AWAKE_BIT 1
`define DPC_STAT_CNT_LSB 16
`define DPC_RESP_OKAY 2'h0
`define DPC_RESP_SLVERR 2'h2

`endif

// >>> verilog/dpc_pkg.sv
// types for the counter-addressed memory port
`default_nettype none
`include "dpc_consts.svh"
package dpc_pkg;

  // control pins of the port, all sampled on the rising edge
  typedef struct packed {
    logic select_active_low;
    logic select_active_high;
    logic address_load_strobe_n;
    logic count_advance_enable_n;
    logic count_clear_n;
    logic read_write_n;
    logic upper_lane_select_n;
    logic lower_lane_select_n;
  } dpc_port_ctrl_t;

  // port state shown to software
  typedef struct packed {
    logic [`DPC_ADDR_W-1:0] count;
    logic awake;
    logic powered_down;
  } dpc_status_t;

endpackage
`default_nettype wire

// >>> verilog/dpc_axil_regs.sv
// axi4-lite register slave for the memory port
`timescale 1ns/1ns
`default_nettype none
`include "dpc_consts.svh"
module dpc_axil_regs (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address
  input wire logic [`DPC_AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read address
  input wire logic [`DPC_AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // block side
  output logic output_latency_select,
  input wire dpc_pkg::dpc_status_t status
);

  logic aw_got_q;
  logic w_got_q;
  logic [`DPC_AXI_AW-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic wstrb0_q;
  logic wr_fire;
  logic [`DPC_AXI_AW-1:0] aw_word;
  logic [`DPC_AXI_AW-1:0] ar_word;
  logic [31:0] rd_word;

  // word addresses, byte offset ignored
  assign aw_word = {awaddr_q[`DPC_AXI_AW-1:2], 2'h0};
  assign ar_word = {s_axi_araddr[`DPC_AXI_AW-1:2], 2'h0};
  assign wr_fire = aw_got_q & w_got_q & ~s_axi_bvalid;

  // write address channel, taken once per transfer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      aw_got_q <= 1'b0;
      awaddr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_got_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_got_q <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  // write data channel, independent of the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      w_got_q <= 1'b0;
      wdata_q <= '0;
      wstrb0_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_got_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb0_q <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_got_q <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  // response once both halves are in; unmapped gives slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DPC_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      if (aw_word == `DPC_OFF_CTRL || aw_word == `DPC_OFF_STATUS) begin
        s_axi_bresp <= `DPC_RESP_OKAY;
      end else begin
        s_axi_bresp <= `DPC_RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // control word, low byte lane only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      output_latency_select <= `DPC_CTRL_PIPE_RST;
    end else if (wr_fire && aw_word == `DPC_OFF_CTRL && wstrb0_q) begin
      output_latency_select <= wdata_q[`DPC_CTRL_PIPE_BIT];
    end
  end

  // read decode
  always_comb begin
    rd_word = 32'h0000_0000;
    if (ar_word == `DPC_OFF_CTRL) begin
      rd_word[`DPC_CTRL_PIPE_BIT] = output_latency_select;
    end else if (ar_word == `DPC_OFF_STATUS) begin
      rd_word[`DPC_STAT_PD_BIT] = status.powered_down;
      rd_word[`DPC_STAT_AWAKE_BIT] = status.awake;
      rd_word[`DPC_STAT_CNT_LSB +: `DPC_ADDR_W] = status.count;
    end
  end

  // read channel, answer one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `DPC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      if (ar_word == `DPC_OFF_CTRL || ar_word == `DPC_OFF_STATUS) begin
        s_axi_rresp <= `DPC_RESP_OKAY;
      end else begin
        s_axi_rresp <= `DPC_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule // dpc_axil_regs
`default_nettype wire

// >>> bench/dpc_ctl_model.sv
// controller model that drives the memory port pins
`timescale 1ns/1ns
`default_nettype none
`include "dpc_consts.svh"
module dpc_ctl_model (
  // clock
  input wire logic aclk,
  // requests from the bench
  input wire dpc_pkg::dpc_port_ctrl_t ctrl_req,
  input wire logic [`DPC_ADDR_W-1:0] addr_req,
  input wire logic [`DPC_DATA_W-1:0] wdata_req,
  // port pins
  output var dpc_pkg::dpc_port_ctrl_t port_ctrl,
  output logic [`DPC_ADDR_W-1:0] port_addr,
  output logic [`DPC_DATA_W-1:0] data_in
);
  logic [`DPC_DATA_W-1:0] junk_q = 18'h15A5A;
  logic wr_sel;

  // pattern that changes every cycle on pins left undriven
  always_ff @(posedge aclk) begin
    junk_q <= ~junk_q ^ 18'h2A5A5;
  end

  // all controls, both selects included, passed straight through from the bench
  assign port_ctrl = ctrl_req;
  assign wr_sel = !ctrl_req.select_active_low && ctrl_req.select_active_high
    && !ctrl_req.read_write_n;
  // address only meaningful while loading
  assign port_addr = ctrl_req.address_load_strobe_n ? junk_q[13:0] : addr_req;
  // data only driven on a selected write
  assign data_in = wr_sel ? wdata_req : junk_q;
endmodule // dpc_ctl_model
`default_nettype wire

// >>> bench/test_sync_dual_port_ram_counter_port.sv
// self-checking bench for the counter-addressed memory port
`timescale 1ns/1ns
`default_nettype none
`include "dpc_consts.svh"
module test_sync_dual_port_ram_counter_port;
  logic aclk = 0, aresetn = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, output_enable_n = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, data_oe, e1, e2, ew1, eo;
  dpc_pkg::dpc_port_ctrl_t ctrl_req = `DPC_CTRL_RST, port_ctrl, c1;
  logic [13:0] addr_req = 0, port_addr, a1, cnt, acc;
  logic [17:0] wdata_req = 0, data_in, data_out, d1, q1, q2, ed;
  logic [17:0] mem [0:16383];
  logic pipe = 0, s1p, sel, prev_rd = 0;
  int fail_count = 0, cmp_count = 0;

  always #25 aclk = ~aclk;

  dpc_ctl_model u_dpc_ctl_model (.aclk(aclk), .ctrl_req(ctrl_req), .addr_req(addr_req),
    .wdata_req(wdata_req), .port_ctrl(port_ctrl), .port_addr(port_addr), .data_in(data_in));
  dpc_port_top u_dpc_port_top (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .port_ctrl(port_ctrl),
    .port_addr(port_addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .output_enable_n(output_enable_n));

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // reference port: acts at the edge after capture, then captures pins
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt = 0; e1 = 0; e2 = 0; ew1 = 0; s1p = 0;
    end else begin
      sel = !c1.select_active_low && c1.select_active_high;
      acc = !c1.count_clear_n ? 14'h0 : !c1.address_load_strobe_n ? a1 :
        !c1.count_advance_enable_n ? cnt + 14'h1 : cnt;
      q2 = q1;
      e2 = ew1;
      q1 = mem[acc];
      e1 = {!c1.upper_lane_select_n, !c1.lower_lane_select_n} & {2{sel && c1.read_write_n}};
      ew1 = e1 & {2{s1p}};
      if (sel && !c1.read_write_n && !c1.upper_lane_select_n) mem[acc][17:9] = d1[17:9];
      if (sel && !c1.read_write_n && !c1.lower_lane_select_n) mem[acc][8:0] = d1[8:0];
      cnt = acc;
      s1p = sel;
    end
    c1 = port_ctrl;
    a1 = port_addr;
    d1 = data_in;
  end

  // outputs compared every cycle where settled
  always @(negedge aclk) begin
    if (aresetn) begin
      eo = (pipe ? e2 : e1) & {2{~output_enable_n}};
      ed = pipe ? q2 : q1;
      chk("data_oe", 32'(eo), 32'(data_oe));
      for (int i = 0; i < 2; i++)
        if (eo[i] && !$isunknown(ed[i*9+:9]))
          chk("data_out lane", 32'(ed[i*9+:9]), 32'(data_out[i*9+:9]));
    end
  end

  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    int t;
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_awvalid <= 1; s_axi_wdata <= d; s_axi_wvalid <= 1;
    s_axi_bready <= 1; aw = 1; w = 1; t = 0;
    while ((aw || w || !s_axi_bvalid) && t < 200) begin
      @(posedge aclk);
      if (aw && s_axi_awready) begin aw = 0; s_axi_awvalid <= 0; end
      if (w && s_axi_wready) begin w = 0; s_axi_wvalid <= 0; end
      t++;
    end
    s_axi_bready <= 0;
    if (t >= 200) fail_count++;
    chk("bresp", 32'(er), 32'(s_axi_bresp));
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
    logic ar;
    int t;
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1; ar = 1; t = 0;
    while ((ar || !s_axi_rvalid) && t < 200) begin
      @(posedge aclk);
      if (ar && s_axi_arready) begin ar = 0; s_axi_arvalid <= 0; end
      t++;
    end
    s_axi_rready <= 0;
    if (t >= 200) fail_count++;
    chk("rresp", 32'(er), 32'(s_axi_rresp));
    chk("rdata", ex, s_axi_rdata);
  endtask

  task automatic step(input dpc_pkg::dpc_port_ctrl_t c, input logic [13:0] a,
                      input logic [17:0] d);
    @(posedge aclk);
    ctrl_req <= c; addr_req <= a; wdata_req <= d;
    prev_rd = !c.select_active_low && c.select_active_high && c.read_write_n;
  endtask

  // selected, both lanes: ld, adv, clr, rd given active high
  function automatic dpc_pkg::dpc_port_ctrl_t mk(input logic ld, adv, clr, rd);
    mk = {1'b0, 1'b1, !ld, !adv, !clr, rd, 2'b00};
  endfunction

  task automatic rnd_step();
    dpc_pkg::dpc_port_ctrl_t c;
    int r;
    r = $urandom_range(0, 9);
    c = {r == 0, r != 1, $urandom_range(0, 2) != 0, $urandom_range(0, 2) != 0,
         $urandom_range(0, 15) != 0, $urandom_range(0, 2) != 0, 2'($urandom_range(0, 3))};
    if (prev_rd && r > 1 && !c.read_write_n) step(`DPC_CTRL_RST, 14'h0, 18'h0);
    output_enable_n <= $urandom_range(0, 7) == 0;
    step(c, 14'($urandom_range(0, 63)) ^ (r == 2 ? 14'h3FC0 : 14'h0), 18'($urandom));
  endtask

  initial begin
    void'($urandom(32'h02551e35));
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    axr(`DPC_OFF_CTRL, 32'h0, `DPC_RESP_OKAY);
    axr(`DPC_OFF_STATUS, 32'h1, `DPC_RESP_OKAY);
    axr(8'h10, 32'h0, `DPC_RESP_SLVERR);
    axw(8'h10, 32'h1, `DPC_RESP_SLVERR);
    axw(`DPC_OFF_STATUS, 32'hFFFF_FFFF, `DPC_RESP_OKAY);
    // control bit ignored without the low byte strobe
    s_axi_wstrb <= 4'hE;
    axw(`DPC_OFF_CTRL, 32'h1, `DPC_RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    axr(`DPC_OFF_CTRL, 32'h0, `DPC_RESP_OKAY);
    for (int p = 0; p < 2; p++) begin
      axw(`DPC_OFF_CTRL, 32'(p), `DPC_RESP_OKAY);
      axr(`DPC_OFF_CTRL, 32'(p), `DPC_RESP_OKAY);
      pipe = p[0];
      step(mk(1, 0, 0, 0), 14'h3FFF, 18'h2A0C3);
      step(mk(0, 1, 0, 0), 14'h0011, 18'h1533C);
      step(mk(0, 1, 1, 0), 14'h0022, 18'h0F0F0);
      step(`DPC_CTRL_RST, 14'h0, 18'h0);
      step(mk(1, 0, 0, 1), 14'h3FFF, 18'h0);
      step(mk(0, 0, 1, 1), 14'h0033, 18'h0);
      step(mk(0, 1, 0, 1), 14'h0044, 18'h0);
      repeat (600) rnd_step();
      output_enable_n <= 0;
      repeat (4) step(mk(0, 0, 0, 1), 14'h0, 18'h0);
      axr(`DPC_OFF_STATUS, {2'b00, cnt, 16'h0002}, `DPC_RESP_OKAY);
      repeat (3) step(`DPC_CTRL_RST, 14'h0, 18'h0);
      axr(`DPC_OFF_STATUS, {2'b00, cnt, 16'h0001}, `DPC_RESP_OKAY);
    end
    results();
  end

  // watchdog well beyond the expected run length
  initial begin
    #1000000;
    fail_count++;
    results();
  end
endmodule // test_sync_dual_port_ram_counter_port
`default_nettype wire
